// File: src/mrs_seq.sv
// Mask ROM read sequencer: pin front end, counters, outputs and APB registers
// Functional notes
// - Serial mode: eighth request fall reads next
// - Byte mode: first request fall reads next
// - Next request advances address counter by one
// - Power-down ignores strobe, request and nibbles
// - Power-down halts ROM decoding and selection
// - Option: outputs float or hold in power-down
// - Power-down clears all four internal counters
// - Power-down follows power-down input level or control register bit
// - Selected and awake: drive ROM data out
// - Not selected: outputs always high impedance
// - Hold only when select code is zero
// - Top address nibble compared with select code
// - Data valid no sooner than access delay
// - Byte mode: eight bits presented together
// - Five strobes, high nibble first, load address
// - Nibble select picks low or high nibble
// - Serial request shifts next higher bit out
`timescale 1ns/10ps
module mrs_seq #(
    parameter logic [mrs_pkg::CS_W-1:0] SELECT_CODE = 4'h0,
    parameter bit                       HOLD_IN_PD  = 1'b0,
    parameter logic [7:0]               ROM_SEED    = 8'h5A
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [mrs_pkg::PADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        power_down,
    input  wire logic                        address_strobe,
    input  wire logic                        data_request,
    input  wire logic                        request_count_mode,
    input  wire logic                        nibble_select,
    input  wire logic [mrs_pkg::NIB_W-1:0]   address_nibble_in,
    output logic      [mrs_pkg::ADDR_W-1:0]  external_address_out,
    output logic                             serial_data_o,
    output logic                             serial_data_oe,
    output logic      [mrs_pkg::BYTE_W-1:0]  parallel_data_pins_o,
    output logic                             parallel_data_pins_oe
);
    mrs_pkg::mrs_pins_s                pins_raw;
    mrs_pkg::mrs_pins_s                pins;
    mrs_pkg::mrs_pins_s                prev_r;
    mrs_pkg::mrs_state_e               state_r;
    logic [mrs_pkg::ADDR_W-1:0]        addr_r;
    logic [mrs_pkg::ADDR_W-1:0]        addr_nxt;
    logic [mrs_pkg::CNT_W-1:0]         strb_cnt_r;
    logic [mrs_pkg::CNT_W-1:0]         strb_cnt_nxt;
    logic [mrs_pkg::CNT_W-1:0]         req_cnt_r;
    logic [mrs_pkg::CNT_W-1:0]         req_cnt_nxt;
    logic [mrs_pkg::BIT_IDX_W-1:0]     bit_idx_r;
    logic [mrs_pkg::BIT_IDX_W-1:0]     bit_idx_nxt;
    logic [mrs_pkg::ACC_W-1:0]         acc_cnt_r;
    logic [mrs_pkg::BYTE_W-1:0]        rom_q;
    logic                              load_r;
    logic                              valid_r;
    logic                              soft_pd_r;
    logic                              serial_r;
    logic [mrs_pkg::BYTE_W-1:0]        par_r;
    logic                              oe_r;
    logic [31:0]                       prdata_r;

    // Pin group into the synchroniser
    assign pins_raw = '{power_down:         power_down,
                        address_strobe:     address_strobe,
                        data_request:       data_request,
                        request_count_mode: request_count_mode,
                        nibble_select:      nibble_select,
                        address_nibble_in:  address_nibble_in};

    mrs_sync #(
        .W (mrs_pkg::PIN_W)
    ) u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    (pins_raw),
        .level_out (pins)
    );

    // Power-down level and qualified falling edges of strobe and request
    wire pd_c       = pins.power_down | soft_pd_r;
    wire strb_fall  = prev_r.address_strobe & ~pins.address_strobe & ~pd_c;
    wire req_fall   = prev_r.data_request & ~pins.data_request & ~pd_c;
    wire byte_mode  = pins.request_count_mode;
    wire strb_last  = strb_fall & (strb_cnt_r == mrs_pkg::STROBE_LAST);
    wire req_last   = req_fall & (byte_mode | (req_cnt_r == mrs_pkg::SERIAL_LAST));
    wire start_c    = strb_last | req_last;
    wire busy_c     = (state_r == mrs_pkg::SEQ_ACCESS);
    wire rd_en_c    = busy_c & (acc_cnt_r == mrs_pkg::ACC_W'(1)) & ~pd_c;
    wire cs_hit     = (addr_r[mrs_pkg::CS_LSB +: mrs_pkg::CS_W] == SELECT_CODE);
    wire hold_ok    = HOLD_IN_PD & (SELECT_CODE == '0);
    wire oe_nxt     = cs_hit & (~pd_c | hold_ok);

    // Address counter: nibble shift-in, next-address increment, clear
    always_comb
    begin
        addr_nxt = addr_r;
        if (pd_c)
            addr_nxt = '0;
        else if (strb_fall)
            addr_nxt = {addr_r[mrs_pkg::ADDR_W-mrs_pkg::NIB_W-1:0],
                        pins.address_nibble_in};
        else if (req_last)
            addr_nxt = addr_r + mrs_pkg::ADDR_W'(1);
    end

    // Strobe counter wraps after the fifth strobe
    always_comb
    begin
        strb_cnt_nxt = strb_cnt_r;
        if (pd_c | strb_last)
            strb_cnt_nxt = '0;
        else if (strb_fall)
            strb_cnt_nxt = strb_cnt_r + mrs_pkg::CNT_W'(1);
    end

    // Request counter; an address load restarts it
    always_comb
    begin
        req_cnt_nxt = req_cnt_r;
        if (pd_c | strb_fall | req_last)
            req_cnt_nxt = '0;
        else if (req_fall)
            req_cnt_nxt = req_cnt_r + mrs_pkg::CNT_W'(1);
    end

    // Serial bit pointer walks upward on each serial-mode request
    always_comb
    begin
        bit_idx_nxt = bit_idx_r;
        if (pd_c | load_r | start_c)
            bit_idx_nxt = '0;
        else if (req_fall & ~byte_mode)
            bit_idx_nxt = bit_idx_r + mrs_pkg::BIT_IDX_W'(1);
    end

    // Counter registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_r     <= '0;
            strb_cnt_r <= '0;
            req_cnt_r  <= '0;
            bit_idx_r  <= '0;
            prev_r     <= '0;
        end
        else
        begin
            addr_r     <= addr_nxt;
            strb_cnt_r <= strb_cnt_nxt;
            req_cnt_r  <= req_cnt_nxt;
            bit_idx_r  <= bit_idx_nxt;
            prev_r     <= pins;
        end
    end

    // Read pulse sequencer: access delay countdown, cleared by power-down
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r   <= mrs_pkg::SEQ_IDLE;
            acc_cnt_r <= '0;
        end
        else if (pd_c)
        begin
            state_r   <= mrs_pkg::SEQ_IDLE;
            acc_cnt_r <= '0;
        end
        else if (start_c)
        begin
            state_r   <= mrs_pkg::SEQ_ACCESS;
            acc_cnt_r <= mrs_pkg::ACC_W'(mrs_pkg::ACCESS_CYCLES);
        end
        else
        begin
            unique case (state_r)
                mrs_pkg::SEQ_IDLE:
                    acc_cnt_r <= '0;
                mrs_pkg::SEQ_ACCESS:
                begin
                    acc_cnt_r <= acc_cnt_r - mrs_pkg::ACC_W'(1);
                    if (rd_en_c)
                        state_r <= mrs_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    mrs_rom #(
        .SEED (ROM_SEED)
    ) u_rom (
        .pclk    (pclk),
        .presetn (presetn),
        .rd_en   (rd_en_c),
        .rd_addr (addr_r[mrs_pkg::ROM_AW-1:0]),
        .rd_data (rom_q)
    );

    // Load marker and data-valid flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            load_r  <= 1'h0;
            valid_r <= 1'h0;
        end
        else
        begin
            load_r  <= rd_en_c;
            valid_r <= ~pd_c & (load_r | (valid_r & ~start_c)); // Fresh load beats a new start
        end
    end

    // Output registers; data frozen in power-down so held data stays put, enable still updated
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_r <= 1'h0;
            par_r    <= '0;
            oe_r     <= 1'h0;
        end
        else
        begin
            oe_r <= oe_nxt;
            if (!pd_c)
            begin
                serial_r <= rom_q[bit_idx_r];
                par_r    <= {rom_q[7:4], pins.nibble_select ? rom_q[7:4]
                                                            : rom_q[3:0]};
            end
        end
    end

    assign external_address_out  = addr_r;
    assign serial_data_o         = serial_r;
    assign parallel_data_pins_o  = par_r;
    assign serial_data_oe        = oe_r;
    assign parallel_data_pins_oe = oe_r;

    // APB decode; zero wait states, error on unmapped words
    wire apb_setup = psel & ~penable;
    wire apb_acc   = psel & penable;
    wire hit_ctrl  = (paddr == mrs_pkg::REG_CTRL);
    wire hit_stat  = (paddr == mrs_pkg::REG_STATUS);
    wire hit_addr  = (paddr == mrs_pkg::REG_ADDR);
    wire hit_data  = (paddr == mrs_pkg::REG_DATA);
    wire hit_any   = hit_ctrl | hit_stat | hit_addr | hit_data;
    wire wr_ctrl   = apb_acc & pwrite & hit_ctrl;

    // Status word assembled from live sequencer state
    logic [31:0] status_w;
    always_comb
    begin
        status_w = mrs_pkg::ZERO_WORD;
        status_w[mrs_pkg::ST_STRB_LSB +: mrs_pkg::CNT_W]     = strb_cnt_r;
        status_w[mrs_pkg::ST_REQ_LSB +: mrs_pkg::CNT_W]      = req_cnt_r;
        status_w[mrs_pkg::ST_BIT_LSB +: mrs_pkg::BIT_IDX_W]  = bit_idx_r;
        status_w[mrs_pkg::ST_PD]    = pd_c;
        status_w[mrs_pkg::ST_SEL]   = cs_hit;
        status_w[mrs_pkg::ST_VALID] = valid_r;
        status_w[mrs_pkg::ST_BUSY]  = busy_c;
    end

    wire [31:0] rd_mux = hit_ctrl ? {31'h0000_0000, soft_pd_r}
                       : hit_stat ? status_w
                       : hit_addr ? {14'h0000, addr_r}
                       : hit_data ? {24'h00_0000, rom_q}
                       : mrs_pkg::ZERO_WORD;

    // Control register written in the access phase; read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            soft_pd_r <= 1'h0;
            prdata_r  <= mrs_pkg::ZERO_WORD;
        end
        else
        begin
            if (wr_ctrl)
                soft_pd_r <= pwdata[mrs_pkg::CTRL_SOFT_PD];
            if (apb_setup)
                prdata_r <= rd_mux;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'h1;
    assign pslverr = apb_acc & ~hit_any;

    // Cycles since the last read start, for access-time checking
    logic [15:0] since_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_r <= '0;
        else if (start_c)
            since_r <= '0;
        else if (since_r != 16'hFFFF)
            since_r <= since_r + 16'h0001;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pd_clears_cnt: assert property (pd_c |=> (addr_r == '0) && (strb_cnt_r == '0)
        && (req_cnt_r == '0) && !busy_c)
        else $error("power-down did not clear counters");
    a_pd_no_read: assert property (pd_c |-> !rd_en_c)
        else $error("ROM read while powered down");
    a_access_min: assert property (rd_en_c |-> since_r == 16'(mrs_pkg::ACCESS_CYCLES - 1))
        else $error("read finished at wrong access delay");
    a_fifth_strobe: assert property (strb_last |=> busy_c && strb_cnt_r == '0)
        else $error("fifth strobe did not start a read");
    a_serial_next: assert property (req_fall && !byte_mode && req_cnt_r == 3'h7
        |=> addr_r == $past(addr_r) + 18'h0_0001 && busy_c)
        else $error("eighth serial request did not advance address");
    a_byte_next: assert property (req_fall && byte_mode
        |=> addr_r == $past(addr_r) + 18'h0_0001 && busy_c)
        else $error("byte request did not advance address");
    a_serial_shift: assert property (req_fall && !byte_mode && req_cnt_r != 3'h7
        |=> bit_idx_r == $past(bit_idx_r) + 3'h1)
        else $error("serial request did not shift bit");
    a_nonsel_float: assert property (!cs_hit |=> !serial_data_oe && !parallel_data_pins_oe)
        else $error("driving while not selected");
    a_sel_drive: assert property (cs_hit && !pd_c |=> serial_data_oe)
        else $error("selected but not driving");
    a_pd_hold: assert property (pd_c && $past(pd_c)
        |=> serial_data_oe == hold_ok && $stable(parallel_data_pins_o))
        else $error("power-down output option misapplied");
    a_pd_ignore: assert property (pd_c && $fell(pins.address_strobe) |-> !strb_fall)
        else $error("strobe accepted in power-down");
endmodule : mrs_seq

// File: src/mrs_pkg.sv
// Shared constants, pin carrier and state type of the mask ROM read sequencer
package mrs_pkg;
    // Address and data geometry
    localparam int ADDR_W    = 18;
    localparam int NIB_W     = 4;
    localparam int BYTE_W    = 8;
    localparam int ROM_AW    = 14;
    localparam int CS_LSB    = 14;
    localparam int CS_W      = 4;
    localparam int BIT_IDX_W = 3;
    localparam int CNT_W     = 3;

    // Strobes per address load and requests per serial byte
    localparam logic [CNT_W-1:0] STROBE_LAST = 3'h4;
    localparam logic [CNT_W-1:0] SERIAL_LAST = 3'h7;

    // Access delay in microseconds and its pclk cycle count (rounded up)
    localparam real PCLK_MHZ        = 10.0;
    localparam real ACCESS_DELAY_US = 26.0;
    localparam int  ACCESS_CYCLES   = int'($ceil(ACCESS_DELAY_US * PCLK_MHZ));
    localparam int  ACC_W           = $clog2(ACCESS_CYCLES + 1);

    // APB register map
    localparam int               PADDR_W     = 12;
    localparam logic [PADDR_W-1:0] REG_CTRL   = 12'h000;
    localparam logic [PADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [PADDR_W-1:0] REG_ADDR   = 12'h008;
    localparam logic [PADDR_W-1:0] REG_DATA   = 12'h00C;
    localparam int               CTRL_SOFT_PD = 0;
    localparam logic [31:0]      ZERO_WORD    = 32'h0000_0000;

    // Status field positions
    localparam int ST_STRB_LSB = 0;
    localparam int ST_REQ_LSB  = 3;
    localparam int ST_BIT_LSB  = 6;
    localparam int ST_PD       = 9;
    localparam int ST_SEL      = 10;
    localparam int ST_VALID    = 11;
    localparam int ST_BUSY     = 12;

    // Pins that pass the synchroniser together
    typedef struct packed {
        logic             power_down;
        logic             address_strobe;
        logic             data_request;
        logic             request_count_mode;
        logic             nibble_select;
        logic [NIB_W-1:0] address_nibble_in;
    } mrs_pins_s;

    localparam int PIN_W = $bits(mrs_pins_s);

    // Read sequencer states
    typedef enum logic {
        SEQ_IDLE,
        SEQ_ACCESS
    } mrs_state_e;
endpackage : mrs_pkg

// File: src/mrs_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module mrs_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Accept a new level once stages two and three agree, per bit
    genvar i;
    for (i = 0; i < W; i++)
    begin : g_agree
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                level_out[i] <= 1'h0;
            else if (s2_r[i] == s3_r[i])
                level_out[i] <= s3_r[i];
        end
    end
endmodule : mrs_sync

// File: src/mrs_rom.sv
// Mask ROM matrix with registered, enable-gated read port
`timescale 1ns/10ps
module mrs_rom #(
    parameter logic [7:0] SEED = 8'h5A
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       rd_en,
    input  wire logic [mrs_pkg::ROM_AW-1:0] rd_addr,
    output logic      [mrs_pkg::BYTE_W-1:0] rd_data
);
    localparam int DEPTH = 1 << mrs_pkg::ROM_AW;

    // Fixed contents; the pattern stands in for the mask programming
    logic [mrs_pkg::BYTE_W-1:0] mem [DEPTH];

    genvar i;
    for (i = 0; i < DEPTH; i++)
    begin : g_cell
        localparam logic [mrs_pkg::ROM_AW-1:0] A = mrs_pkg::ROM_AW'(i);
        assign mem[i] = A[7:0] ^ {A[13:8], 2'h0} ^ SEED;
    end

    // Decoder and selector idle while the enable is low; data holds
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_data <= '0;
        else if (rd_en)
            rd_data <= mem[rd_addr];
    end
endmodule : mrs_rom

// File: dv/mrs_ctl_model.sv
// Controller model: drives address strobes, nibbles and data requests
`timescale 1ns/10ps
module mrs_ctl_model (
    input  wire logic                    pclk,
    output logic                         address_strobe,
    output logic                         data_request,
    output logic [mrs_pkg::NIB_W-1:0]    address_nibble_in
);
    // Idle pins at time zero
    initial
    begin
        address_strobe = 1'b0;
        data_request = 1'b0;
        address_nibble_in = 4'h0;
    end

    // Five strobes, top nibble first, request held low; nibble inverted once released
    task automatic load(input logic [mrs_pkg::ADDR_W-1:0] addr);
        logic [19:0] word;
        word = {2'b00, addr};
        for (int i = 4; i >= 0; i--)
        begin
            @(posedge pclk);
            address_nibble_in <= word[i*4 +: 4];
            address_strobe <= 1'b1;
            repeat (4) @(posedge pclk);
            address_strobe <= 1'b0;
            repeat (3) @(posedge pclk);
            address_nibble_in <= ~word[i*4 +: 4];
        end
    endtask : load

    // One request pulse, four cycles high and four low
    task automatic request();
        @(posedge pclk);
        data_request <= 1'b1;
        repeat (4) @(posedge pclk);
        data_request <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : request
endmodule : mrs_ctl_model

// File: dv/testbench.sv
// Self-checking testbench for the mask ROM read sequencer
`timescale 1ns/10ps
module testbench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        power_down;
    logic        mode;
    logic        nib_sel;
    logic        strobe;
    logic        req;
    logic [3:0]  nib;
    logic [17:0] ext_addr;
    logic        ser_o;
    logic        ser_oe;
    logic [7:0]  par_o;
    logic        par_oe;
    logic [31:0] rdata;
    logic        rerr;
    int          err_count;
    int          comparisons;
    int          cycles;

    mrs_seq uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_down(power_down),
        .address_strobe(strobe), .data_request(req), .request_count_mode(mode),
        .nibble_select(nib_sel), .address_nibble_in(nib),
        .external_address_out(ext_addr), .serial_data_o(ser_o),
        .serial_data_oe(ser_oe), .parallel_data_pins_o(par_o),
        .parallel_data_pins_oe(par_oe));

    mrs_ctl_model ctl (.pclk(pclk), .address_strobe(strobe), .data_request(req),
        .address_nibble_in(nib));

    // Clock of 100 ns period
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Hang guard
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 10000)
        begin
            err_count++;
            test_done();
        end
    end

    // Expected ROM byte at an address
    function automatic logic [7:0] exp_byte(input logic [17:0] a);
        return a[7:0] ^ {a[13:8], 2'b00} ^ 8'h5A;
    endfunction : exp_byte

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: %s", $time, m);
            err_count++;
        end
    endtask : chk

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never re-drives psel in this step
        @(posedge pclk);
    endtask : apb

    // Register access kinds and unmapped address
    task automatic t_regs();
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(rerr), 32'h1, "unmapped error");
        chk(rdata, 32'h0, "unmapped data");
        apb(1'b1, mrs_pkg::REG_CTRL, 32'h0000_0001);
        apb(1'b0, mrs_pkg::REG_CTRL, 32'h0);
        chk(rdata, 32'h0000_0001, "ctrl readback");
        apb(1'b0, mrs_pkg::REG_STATUS, 32'h0);
        chk(32'(rdata[9]), 32'h1, "soft power-down");
        apb(1'b1, mrs_pkg::REG_CTRL, 32'h0);
        apb(1'b1, mrs_pkg::REG_DATA, 32'hFFFF_FFFF);
        apb(1'b0, mrs_pkg::REG_DATA, 32'h0);
        chk(rdata, 32'h0, "read-only data");
    endtask : t_regs

    // Serial read across the select boundary
    task automatic t_serial();
        logic [7:0] b;
        b = exp_byte(18'h0_3FFF);
        mode <= 1'b0;
        ctl.load(18'h0_3FFF);
        repeat (200) @(posedge pclk);
        chk(32'(par_o), 32'h0, "early data");
        repeat (100) @(posedge pclk);
        chk(32'(ext_addr), 32'h0_3FFF, "loaded address");
        chk(32'(par_o), 32'(b), "parallel byte");
        chk(32'({ser_oe, par_oe}), 32'h3, "selected drive");
        for (int k = 0; k < 8; k++)
        begin
            chk(32'(ser_o), 32'(b[k]), "serial bit");
            chk(32'(ext_addr), 32'h0_3FFF, "address before eighth");
            ctl.request();
            repeat (4) @(posedge pclk);
        end
        repeat (306) @(posedge pclk);
        chk(32'(ext_addr), 32'h0_4000, "next address");
        chk(32'({ser_oe, par_oe}), 32'h0, "nonselect float");
    endtask : t_serial

    // Byte mode with nibble selection
    task automatic t_byte();
        logic [7:0] b;
        b = exp_byte(18'h0_1234);
        mode <= 1'b1;
        ctl.load(18'h0_1234);
        repeat (300) @(posedge pclk);
        chk(32'(par_o), 32'(b), "byte mode data");
        apb(1'b0, mrs_pkg::REG_STATUS, 32'h0);
        chk(32'(rdata[12:10]), 32'h3, "selected, valid, idle");
        nib_sel <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(32'(par_o[3:0]), 32'(b[7:4]), "high nibble");
        nib_sel <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(32'(par_o[3:0]), 32'(b[3:0]), "low nibble");
        ctl.request();
        repeat (306) @(posedge pclk);
        chk(32'(ext_addr), 32'h0_1235, "byte next address");
        chk(32'(par_o), 32'(exp_byte(18'h0_1235)), "byte next data");
    endtask : t_byte

    // Power-down clears counters, floats outputs, ignores pins
    task automatic t_pd();
        power_down <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(32'(ext_addr), 32'h0, "address cleared");
        chk(32'({ser_oe, par_oe}), 32'h0, "float in sleep");
        apb(1'b0, mrs_pkg::REG_STATUS, 32'h0);
        chk(32'(rdata[9:0]), 32'h200, "counters cleared");
        ctl.load(18'h0_0777);
        ctl.request();
        repeat (300) @(posedge pclk);
        chk(32'(ext_addr), 32'h0, "pins ignored");
        apb(1'b0, mrs_pkg::REG_DATA, 32'h0);
        chk(rdata, 32'(exp_byte(18'h0_1235)), "no ROM read asleep");
        power_down <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, mrs_pkg::REG_STATUS, 32'h0);
        chk(32'(rdata[9]), 32'h0, "awake");
        ctl.load(18'h2_0055);
        repeat (300) @(posedge pclk);
        chk(32'(ext_addr), 32'h2_0055, "reload address");
        chk(32'({ser_oe, par_oe}), 32'h0, "other code float");
    endtask : t_pd

    task automatic test_done();
        $display("comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // Main sequence
    initial
    begin
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        power_down = 1'b0;
        mode = 1'b0;
        nib_sel = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        t_regs();
        t_serial();
        t_byte();
        t_pd();
        test_done();
    end
endmodule : testbench
